// ===== seq_state_pkg.sv
// Constants for the self-test sequencer state register block.
package seq_state_pkg;
	localparam int          PROG_LEN_DEFAULT   = 32;
	localparam int          DEPTH_WIDTH_DEF    = 5;
	localparam logic [7:0]  OFS_CTRL           = 8'h00;
	localparam logic [7:0]  OFS_PROG_COUNTER   = 8'h04;
	localparam logic [7:0]  OFS_READ_PIPELINE  = 8'h08;
	localparam logic [7:0]  OFS_LOW_BOUND      = 8'h0C;
	localparam logic [7:0]  OFS_IRQ_STATUS     = 8'h10;
	localparam logic [7:0]  OFS_IRQ_CLEAR      = 8'h14;
	localparam logic [7:0]  OFS_IRQ_ENABLE     = 8'h18;
	localparam int          CTRL_EXEC_BIT      = 0;
	localparam int          CTRL_STOP_BIT      = 1;
	localparam int          CTRL_LSP_LSB       = 8;
	localparam int          CTRL_PD_LSB        = 16;
	localparam int          CTRL_PDP_LSB       = 24;
	localparam int          FIELD_W            = 5;
	localparam int          STAT_FAULT_BIT     = 0;
	localparam int          STAT_LOOP_BIT      = 1;
	localparam int          STAT_W             = 2;
	localparam logic [31:0] RESET_WORD         = 32'h0000_0000;
	localparam logic [1:0]  STAT_RESET         = 2'h0;
endpackage

// ===== read_pipe_shift.sv
// Read pipeline shift register tracking reads in flight.
`timescale 1ns/1ns
`default_nettype none
module read_pipe_shift
	import seq_state_pkg::*;
#(
	parameter int DW = DEPTH_WIDTH_DEF
)
(
	input  wire logic                mclk_in,
	input  wire logic                nrst_in,
	input  wire logic                ce_in,
	input  wire logic                clear_in,
	input  wire logic                advance_in,
	input  wire logic                read_in,
	input  wire logic [DW-1:0]       depth_in,
	output logic      [(2**DW)-1:0]  pipe_out
);
	localparam int W = 2 ** DW;

	typedef struct packed
	{
		logic [W-1:0] pipe;
	} pipe_state_t;

	pipe_state_t       state_reg;
	pipe_state_t       state_next;
	logic    [W-1:0]   keep_mask;

	always_comb
	begin
		state_next = state_reg;
		keep_mask  = '0;
		for (int i = 0; i < W; i++)
		begin
			keep_mask[i] = (i <= int'(depth_in));
		end
		if (clear_in)
		begin
			state_next.pipe = '0;
		end
		else if (advance_in)
		begin
			// Shift and insert the new read marker in one step.
			state_next.pipe = {state_reg.pipe[W-2:0], read_in} & keep_mask;
		end
	end

	always_ff @(posedge mclk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			state_reg <= '0;
		end
		else if (ce_in)
		begin
			state_reg <= state_next;
		end
	end

	assign pipe_out = state_reg.pipe;

	a_pipe_shift_left: assert property (@(posedge mclk_in) disable iff (!nrst_in)
		ce_in && advance_in && !clear_in && depth_in != '0
		|=> pipe_out[1] == $past(pipe_out[0]) && pipe_out[0] == $past(read_in))
		else $error("read pipeline did not shift left");
	a_pipe_upper_zero: assert property (@(posedge mclk_in) disable iff (!nrst_in)
		ce_in && advance_in |=> (pipe_out & ~$past(keep_mask)) == '0)
		else $error("read pipeline bits above depth not zero");
	a_pipe_start_clear: assert property (@(posedge mclk_in) disable iff (!nrst_in)
		ce_in && clear_in |=> pipe_out == '0)
		else $error("read pipeline not cleared at start");
	c_pipe_two_reads: cover property (@(posedge mclk_in) disable iff (!nrst_in)
		$countones(pipe_out) >= 2);
endmodule
`default_nettype wire

// ===== seq_state_regs.sv
// Sequencer state registers with APB access and an interrupt on a stop-on-fault halt or a finished loop.
//
// Added by the designer: the APB register port and the address map.
`timescale 1ns/1ns
`default_nettype none
module seq_state_regs
	import seq_state_pkg::*;
#(
	parameter int PROG_LEN = PROG_LEN_DEFAULT,
	parameter int DW       = DEPTH_WIDTH_DEF
)
(
	input  wire logic         mclk_in,
	input  wire logic         nrst_in,
	input  wire logic         ce_in,
	input  wire logic         psel_in,
	input  wire logic         penable_in,
	input  wire logic         pwrite_in,
	input  wire logic [7:0]   paddr_in,
	input  wire logic [31:0]  pwdata_in,
	output logic      [31:0]  prdata_out,
	output logic              pready_out,
	output logic              pslverr_out,
	input  wire logic         instr_exec_in,
	input  wire logic         instr_read_in,
	input  wire logic         instr_loop_in,
	input  wire logic         prot_path_in,
	input  wire logic         addr_mode_inc_in,
	input  wire logic [31:0]  cur_addr_in,
	input  wire logic         other_end_in,
	input  wire logic         mem_fault_in,
	input  wire logic         prot_fault_in,
	output logic              running_out,
	output logic      [$clog2(PROG_LEN)-1:0] prog_counter_out,
	output logic              irq_out
);
	localparam int PCW = $clog2(PROG_LEN);
	localparam int RW  = 2 ** DW;

	typedef struct packed
	{
		logic                program_execution_enable;
		logic                stop_on_fault;
		logic [PCW-1:0]      prog_counter;
		logic [PCW-1:0]      loop_start_pointer;
		logic [DW-1:0]       pipeline_depth;
		logic [DW-1:0]       protection_pipeline_depth;
		logic [31:0]         low_bound_addr;
		logic [STAT_W-1:0]   status;
		logic [STAT_W-1:0]   enable;
		logic                ready;
		logic                slverr;
		logic [31:0]         rdata;
		logic                irq;
	} regs_state_t;

	regs_state_t        state_reg;
	regs_state_t        state_next;
	logic    [RW-1:0]   pipe;
	logic               setup;
	logic               wr_access;
	logic               start;
	logic               step;
	logic               loop_end;
	logic    [DW-1:0]   depth;
	logic               fault_hit;
	logic               halt;
	logic    [STAT_W-1:0] set_bits;
	logic    [31:0]     read_word;
	logic               mapped;

	always_comb
	begin
		setup     = psel_in && !penable_in;
		wr_access = psel_in && penable_in && state_reg.ready && pwrite_in
			&& !state_reg.slverr;
		start     = wr_access && paddr_in == OFS_CTRL
			&& pwdata_in[CTRL_EXEC_BIT] && !state_reg.program_execution_enable;
		step      = state_reg.program_execution_enable && instr_exec_in;
		depth     = prot_path_in ? state_reg.protection_pipeline_depth
			: state_reg.pipeline_depth;
		// A compare result is only trusted once its read marker has reached
		// the depth bit, so a stray fault pulse cannot stop the test.
		fault_hit = (mem_fault_in || prot_fault_in) && pipe[depth];
		halt      = state_reg.program_execution_enable
			&& state_reg.stop_on_fault && fault_hit;
		loop_end  = addr_mode_inc_in ? (cur_addr_in == state_reg.low_bound_addr)
			: other_end_in;
	end

	always_comb
	begin
		mapped    = 1'b1;
		read_word = RESET_WORD;
		unique case (paddr_in)
			OFS_CTRL:
			begin
				read_word[CTRL_EXEC_BIT] = state_reg.program_execution_enable;
				read_word[CTRL_STOP_BIT] = state_reg.stop_on_fault;
				read_word[CTRL_LSP_LSB +: PCW] = state_reg.loop_start_pointer;
				read_word[CTRL_PD_LSB +: DW] = state_reg.pipeline_depth;
				read_word[CTRL_PDP_LSB +: DW] = state_reg.protection_pipeline_depth;
			end
			OFS_PROG_COUNTER:  read_word[PCW-1:0] = state_reg.prog_counter;
			OFS_READ_PIPELINE: read_word[RW-1:0] = pipe;
			OFS_LOW_BOUND:     read_word = state_reg.low_bound_addr;
			OFS_IRQ_STATUS:    read_word[STAT_W-1:0] = state_reg.status;
			OFS_IRQ_CLEAR:     read_word = RESET_WORD;
			OFS_IRQ_ENABLE:    read_word[STAT_W-1:0] = state_reg.enable;
			default:           mapped = 1'b0;
		endcase
	end

	always_comb
	begin
		state_next = state_reg;
		set_bits   = '0;
		state_next.ready  = setup;
		state_next.slverr = setup && !mapped;
		if (setup && !pwrite_in)
		begin
			state_next.rdata = read_word;
		end
		if (wr_access)
		begin
			unique case (paddr_in)
				OFS_CTRL:
				begin
					state_next.program_execution_enable = pwdata_in[CTRL_EXEC_BIT];
					state_next.stop_on_fault = pwdata_in[CTRL_STOP_BIT];
					state_next.loop_start_pointer = pwdata_in[CTRL_LSP_LSB +: PCW];
					state_next.pipeline_depth = pwdata_in[CTRL_PD_LSB +: DW];
					state_next.protection_pipeline_depth =
						pwdata_in[CTRL_PDP_LSB +: DW];
				end
				OFS_PROG_COUNTER:
					state_next.prog_counter = pwdata_in[PCW-1:0];
				OFS_LOW_BOUND:  state_next.low_bound_addr = pwdata_in;
				OFS_IRQ_CLEAR:  state_next.status = state_reg.status & ~pwdata_in[STAT_W-1:0];
				OFS_IRQ_ENABLE: state_next.enable = pwdata_in[STAT_W-1:0];
				default:        state_next.status = state_next.status;
			endcase
		end
		// Execution moves the counter; it takes priority over a software
		// write in the same cycle because the program is live.
		if (step && !halt)
		begin
			if (instr_loop_in && !loop_end)
			begin
				state_next.prog_counter = state_reg.loop_start_pointer;
			end
			else
			begin
				state_next.prog_counter = state_reg.prog_counter + 1'b1;
				set_bits[STAT_LOOP_BIT] = instr_loop_in;
			end
		end
		if (halt)
		begin
			// Halting drops the enable and sets the fault status; counter and pipeline hold.
			state_next.program_execution_enable = 1'b0;
			set_bits[STAT_FAULT_BIT] = 1'b1;
		end
		// An event in the clearing cycle still lands.
		state_next.status = state_next.status | set_bits;
		state_next.irq    = |(state_next.status & state_next.enable);
	end

	always_ff @(posedge mclk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			state_reg <= '0;
		end
		else if (ce_in)
		begin
			state_reg <= state_next;
		end
	end

	read_pipe_shift #(
		.DW         (DW)
	) u_pipe (
		.mclk_in    (mclk_in),
		.nrst_in    (nrst_in),
		.ce_in      (ce_in),
		.clear_in   (start),
		.advance_in (state_reg.program_execution_enable && !halt),
		.read_in    (step && instr_read_in),
		.depth_in   (depth),
		.pipe_out   (pipe)
	);

	assign prdata_out       = state_reg.rdata;
	assign pready_out       = state_reg.ready;
	assign pslverr_out      = state_reg.slverr;
	assign running_out      = state_reg.program_execution_enable;
	assign prog_counter_out = state_reg.prog_counter;
	assign irq_out          = state_reg.irq;

	a_pc_step_inc: assert property (@(posedge mclk_in) disable iff (!nrst_in)
		ce_in && step && !fault_hit && !instr_loop_in
		|=> prog_counter_out == PCW'($past(prog_counter_out) + 1'b1))
		else $error("counter did not step after instruction");
	a_pc_loop_load: assert property (@(posedge mclk_in) disable iff (!nrst_in)
		ce_in && step && !fault_hit && instr_loop_in && !loop_end
		|=> prog_counter_out == $past(state_reg.loop_start_pointer))
		else $error("loop did not reload start pointer");
	a_pc_read_width: assert property (@(posedge mclk_in) disable iff (!nrst_in)
		ce_in && setup && !pwrite_in && paddr_in == OFS_PROG_COUNTER
		|=> prdata_out[31:PCW] == '0 && prdata_out[PCW-1:0] == $past(prog_counter_out))
		else $error("counter readback wrong");
	a_rpr_read_only: assert property (@(posedge mclk_in) disable iff (!nrst_in)
		ce_in && wr_access && paddr_in == OFS_READ_PIPELINE && !running_out
		|=> $stable(pipe))
		else $error("pipeline changed on software write");
	a_fault_halt_keep: assert property (@(posedge mclk_in) disable iff (!nrst_in)
		ce_in && running_out && fault_hit && state_reg.stop_on_fault
		|=> !running_out && $stable(prog_counter_out) && $stable(pipe)
		##1 !running_out)
		else $error("stop on fault did not halt and hold");
	a_fault_depth_bit: assert property (@(posedge mclk_in) disable iff (!nrst_in)
		ce_in && $rose(state_reg.status[STAT_FAULT_BIT])
		|-> $past(pipe[depth]))
		else $error("halt without marker at depth");
	a_loop_low_bound: assert property (@(posedge mclk_in) disable iff (!nrst_in)
		ce_in && step && !fault_hit && instr_loop_in && addr_mode_inc_in
		&& cur_addr_in == state_reg.low_bound_addr
		|=> prog_counter_out == PCW'($past(prog_counter_out) + 1'b1))
		else $error("loop end at low bound not honoured");
	a_irq_level: assert property (@(posedge mclk_in) disable iff (!nrst_in)
		irq_out == |(state_reg.status & state_reg.enable))
		else $error("interrupt not tied to enabled status");
	a_ce_freeze: assert property (
		@(posedge mclk_in) disable iff (!nrst_in)
		!ce_in |=> $stable(prog_counter_out) && $stable(running_out)
		&& $stable(pipe) && $stable(irq_out))
		else $error("state moved while clock enable low");
	a_idle_no_step: assert property (
		@(posedge mclk_in) disable iff (!nrst_in)
		ce_in && !running_out
		&& !(wr_access && paddr_in == OFS_PROG_COUNTER)
		|=> $stable(prog_counter_out))
		else $error("counter moved while not running");
	a_ready_answer: assert property (
		@(posedge mclk_in) disable iff (!nrst_in)
		ce_in && setup |=> pready_out)
		else $error("no ready in the access cycle");
	a_ready_pulse: assert property (
		@(posedge mclk_in) disable iff (!nrst_in)
		ce_in && pready_out && penable_in |=> !pready_out)
		else $error("ready held beyond one cycle");
	a_unmapped_err: assert property (
		@(posedge mclk_in) disable iff (!nrst_in)
		ce_in && setup && !mapped |=> pready_out && pslverr_out)
		else $error("unmapped access not flagged");
	a_start_clears: assert property (
		@(posedge mclk_in) disable iff (!nrst_in)
		ce_in && start |=> running_out && pipe == '0)
		else $error("start did not run with an empty pipeline");
	a_status_sticky: assert property (
		@(posedge mclk_in) disable iff (!nrst_in)
		ce_in && state_reg.status[STAT_FAULT_BIT]
		&& !(wr_access && paddr_in == OFS_IRQ_CLEAR)
		|=> state_reg.status[STAT_FAULT_BIT])
		else $error("fault status lost without a clear");
	a_low_bound_write: assert property (
		@(posedge mclk_in) disable iff (!nrst_in)
		ce_in && wr_access && paddr_in == OFS_LOW_BOUND
		|=> state_reg.low_bound_addr == $past(pwdata_in))
		else $error("low bound write did not land");
	a_pipe_view: assert property (
		@(posedge mclk_in) disable iff (!nrst_in)
		ce_in && setup && !pwrite_in && paddr_in == OFS_READ_PIPELINE
		|=> prdata_out[RW-1:0] == $past(pipe))
		else $error("pipeline readback wrong");
	a_loop_done_flag: assert property (
		@(posedge mclk_in) disable iff (!nrst_in)
		ce_in && step && !halt && instr_loop_in && loop_end
		|=> state_reg.status[STAT_LOOP_BIT])
		else $error("finished loop not flagged");
	c_loop_reload: cover property (@(posedge mclk_in) disable iff (!nrst_in)
		step && instr_loop_in && !loop_end);
	c_fault_halt: cover property (@(posedge mclk_in) disable iff (!nrst_in)
		running_out && fault_hit && state_reg.stop_on_fault);
	c_start_run: cover property (@(posedge mclk_in) disable iff (!nrst_in)
		start ##1 running_out ##1 step);
	c_fault_no_stop: cover property (@(posedge mclk_in) disable iff (!nrst_in)
		running_out && fault_hit && !state_reg.stop_on_fault);
endmodule
`default_nettype wire

// ===== mem_fault_model.sv
// Memory array model that fails a read when its marker reaches the depth.
`timescale 1ns/1ns
`default_nettype none
module mem_fault_model
(
	input  wire logic       mclk_in,
	input  wire logic       nrst_in,
	input  wire logic       running_in,
	input  wire logic       exec_in,
	input  wire logic       read_in,
	input  wire logic       inject_in,
	input  wire logic [4:0] depth_in,
	output logic            fault_out
);
	logic [31:0] track_reg;
	// Markers are dropped once the sequencer halts, as no compare is pending.
	always_ff @(posedge mclk_in or negedge nrst_in)
	begin
		if (!nrst_in)
			track_reg <= 32'h0000_0000;
		else if (!running_in)
			track_reg <= 32'h0000_0000;
		else
			track_reg <= {track_reg[30:0], exec_in & read_in};
	end
	assign fault_out = inject_in & track_reg[depth_in];
endmodule
`default_nettype wire

// ===== seq_state_regs_tb.sv
// Self-checking bench for the sequencer state registers.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin failures++; \
$display("unexpected at %0t: got %h expected %h", $time, (a), (e)); end end
module seq_state_regs_tb
	import seq_state_pkg::*;
;
	logic        clk = 1'b0, nrst = 1'b0, psel = 1'b0, pen = 1'b0;
	logic        pwr = 1'b0, ex = 1'b0, rd = 1'b0, lp = 1'b0, prot = 1'b0;
	logic        inc = 1'b0, oend = 1'b0, inj = 1'b0, fault, prdy, perr;
	logic        run, irq, err, ce = 1'b1;
	logic [7:0]  addr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000, cur = 32'h0000_0000, prdata, rv;
	logic [4:0]  pc, dep = 5'h00;
	int          failures = 0, cmp_count = 0;
	seq_state_regs dut (.mclk_in(clk), .nrst_in(nrst), .ce_in(ce),
		.psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(addr),
		.pwdata_in(wdata), .prdata_out(prdata), .pready_out(prdy),
		.pslverr_out(perr), .instr_exec_in(ex), .instr_read_in(rd),
		.instr_loop_in(lp), .prot_path_in(prot), .addr_mode_inc_in(inc),
		.cur_addr_in(cur), .other_end_in(oend),
		.mem_fault_in(fault & ~prot), .prot_fault_in(fault & prot),
		.running_out(run), .prog_counter_out(pc),
		.irq_out(irq));
	mem_fault_model mem (.mclk_in(clk), .nrst_in(nrst), .running_in(run),
		.exec_in(ex), .read_in(rd), .inject_in(inj), .depth_in(dep),
		.fault_out(fault));
	initial
	begin
		forever #10 clk = ~clk;
	end
	function automatic logic [31:0] cw(input logic [1:0] es,
		input logic [4:0] l, input logic [4:0] p, input logic [4:0] q);
		return (32'(es) << CTRL_EXEC_BIT) | (32'(l) << CTRL_LSP_LSB) |
			(32'(p) << CTRL_PD_LSB) | (32'(q) << CTRL_PDP_LSB);
	endfunction
	// The master waits on pready for up to 40 cycles, then counts a failure.
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= w;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (prdy !== 1'b1 && n < 40);
		if (n >= 40)
			failures++;
		rv = prdata;
		err = perr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	task automatic instr(input logic r, input logic l);
		@(posedge clk);
		ex <= 1'b1;
		rd <= r;
		lp <= l;
		@(posedge clk);
		ex <= 1'b0;
	endtask
	task automatic pc_is(input logic [4:0] e);
		@(posedge clk);
		`CHK(pc, e)
	endtask
	task automatic t_reset();
		apb(1'b0, OFS_PROG_COUNTER, RESET_WORD);
		`CHK(rv, RESET_WORD)
		apb(1'b1, OFS_READ_PIPELINE, 32'hFFFF_FFFF);
		apb(1'b0, OFS_READ_PIPELINE, RESET_WORD);
		`CHK(rv, RESET_WORD)
		apb(1'b1, OFS_PROG_COUNTER, 32'hFFFF_FFFE);
		apb(1'b0, OFS_PROG_COUNTER, RESET_WORD);
		`CHK(rv, 32'h0000_001E)
		apb(1'b0, 8'h1C, RESET_WORD);
		`CHK(err, 1'b1)
		$display("test reset done");
	endtask
	task automatic t_count();
		apb(1'b1, OFS_CTRL, cw(2'h1, 5'h00, 5'h03, 5'h03));
		instr(1'b0, 1'b0);
		pc_is(5'h1F);
		instr(1'b0, 1'b0);
		instr(1'b0, 1'b0);
		pc_is(5'h01);
		ce <= 1'b0;
		instr(1'b0, 1'b0);
		pc_is(5'h01);
		ce <= 1'b1;
		apb(1'b1, OFS_CTRL, RESET_WORD);
		instr(1'b0, 1'b0);
		pc_is(5'h01);
		$display("test count done");
	endtask
	task automatic t_loop();
		apb(1'b1, OFS_PROG_COUNTER, 32'h0000_0005);
		apb(1'b1, OFS_LOW_BOUND, 32'h0000_0040);
		apb(1'b0, OFS_LOW_BOUND, RESET_WORD);
		`CHK(rv, 32'h0000_0040)
		apb(1'b1, OFS_CTRL, cw(2'h1, 5'h02, 5'h03, 5'h03));
		inc <= 1'b1;
		cur <= 32'h0000_0041;
		instr(1'b0, 1'b1);
		pc_is(5'h02);
		cur <= 32'h0000_0040;
		instr(1'b0, 1'b1);
		pc_is(5'h03);
		apb(1'b0, OFS_IRQ_STATUS, RESET_WORD);
		`CHK(rv, 32'h0000_0002)
		inc <= 1'b0;
		instr(1'b0, 1'b1);
		pc_is(5'h02);
		oend <= 1'b1;
		instr(1'b0, 1'b1);
		pc_is(5'h03);
		apb(1'b1, OFS_CTRL, RESET_WORD);
		apb(1'b1, OFS_IRQ_CLEAR, 32'h0000_0003);
		$display("test loop done");
	endtask
	// Without stop on fault the program runs on through a fault.
	task automatic t_nostop();
		apb(1'b1, OFS_PROG_COUNTER, RESET_WORD);
		prot <= 1'b0;
		inj <= 1'b1;
		dep <= 5'h03;
		apb(1'b1, OFS_CTRL, cw(2'h1, 5'h00, 5'h03, 5'h03));
		instr(1'b1, 1'b0);
		instr(1'b1, 1'b0);
		instr(1'b0, 1'b0);
		repeat (6) @(posedge clk);
		`CHK(run, 1'b1)
		pc_is(5'h03);
		inj <= 1'b0;
		apb(1'b1, OFS_CTRL, RESET_WORD);
		apb(1'b0, OFS_IRQ_STATUS, RESET_WORD);
		`CHK(rv, RESET_WORD)
		$display("test no-stop done");
	endtask
	task automatic t_fault(input logic pp, input int d);
		int n;
		n = 0;
		apb(1'b1, OFS_PROG_COUNTER, 32'h0000_0004);
		prot <= pp;
		inj <= 1'b1;
		dep <= 5'(d);
		apb(1'b1, OFS_CTRL, cw(2'h3, 5'h00, pp ? 5'h07 : 5'(d),
			pp ? 5'(d) : 5'h07));
		cur <= 32'h0000_0010;
		instr(1'b1, 1'b0);
		cur <= 32'h0000_0011;
		instr(1'b1, 1'b0);
		while (run !== 1'b0 && n < 30)
		begin
			@(posedge clk);
			n++;
		end
		`CHK(run, 1'b0)
		apb(1'b0, OFS_READ_PIPELINE, RESET_WORD);
		`CHK(rv, (32'h1 << d) | (32'h1 << (d - 2)))
		n = $countones(rv);
		apb(1'b0, OFS_PROG_COUNTER, RESET_WORD);
		`CHK(rv, 32'h0000_0006)
		`CHK(rv - 32'(n), 32'h0000_0004)
		`CHK(cur - 32'(n - 1), 32'h0000_0010)
		apb(1'b0, OFS_IRQ_STATUS, RESET_WORD);
		`CHK(rv, 32'h0000_0001)
		`CHK(irq, 1'b0)
		apb(1'b1, OFS_IRQ_ENABLE, 32'h0000_0001);
		repeat (2) @(posedge clk);
		`CHK(irq, 1'b1)
		apb(1'b1, OFS_IRQ_CLEAR, 32'h0000_0001);
		repeat (2) @(posedge clk);
		`CHK(irq, 1'b0)
		inj <= 1'b0;
		apb(1'b1, OFS_CTRL, RESET_WORD);
		apb(1'b1, OFS_CTRL, cw(2'h1, 5'h00, 5'h03, 5'h03));
		apb(1'b0, OFS_READ_PIPELINE, RESET_WORD);
		`CHK(rv, RESET_WORD)
		apb(1'b1, OFS_CTRL, RESET_WORD);
		apb(1'b1, OFS_IRQ_ENABLE, RESET_WORD);
		$display("test fault done");
	endtask
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial
	begin
		#200000;
		failures++;
		give_verdict();
	end
	initial
	begin
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		t_reset();
		t_count();
		t_loop();
		t_nostop();
		t_fault(1'b0, 3);
		t_fault(1'b1, 6);
		give_verdict();
	end
endmodule
`default_nettype wire
